// ==== design/pcr_regs.svh ====
// register map, field positions, reset values and timing counts of the
// per-channel calibration register bank
// assumes a 7-bit register address and 16-bit register words
`ifndef PCR_REGS_SVH
`define PCR_REGS_SVH

// register addresses
`define PCR_ADDR_CAL_REQ   7'h10
`define PCR_ADDR_MAILBOX   7'h11
`define PCR_ADDR_STATE     7'h12
`define PCR_ADDR_TRIM      7'h13
`define PCR_ADDR_PEND_OFF  7'h20

// request field positions inside cal_request
`define PCR_REQ_PHASE_LSB  6
`define PCR_REQ_GAIN_LSB   4
`define PCR_REQ_OFFSET_LSB 2
`define PCR_XFER_GO        2'h2

// channel selector codes
`define PCR_SEL_CH0        3'h1
`define PCR_SEL_CH1        3'h2
`define PCR_SEL_CH2        3'h3
`define PCR_SEL_CH3        3'h4

// reset values
`define PCR_TRIM_RST       4'h7
`define PCR_CORR_RST       10'h200

// serial frame: 1 direction bit, 7 address bits, 16 data bits
`define PCR_HDR_BITS       5'h08
`define PCR_FRAME_BITS     5'h18

// cycles that one correction transfer takes
`define PCR_XFER_CYCLES    4

`endif

// ==== design/pcr_pkg.sv ====
// types shared by the per-channel calibration register bank
// assumes the constants of pcr_regs.svh for field sizes
package pcr_pkg;

   // transfer sequencer states
   typedef enum logic [1:0] {
      PCR_SEQ_IDLE,
      PCR_SEQ_GAIN,
      PCR_SEQ_OFFSET,
      PCR_SEQ_PHASE
   } pcr_seq_t;

   // state of the register bank
   typedef struct packed {
      logic [3:0][5:0] cal_req;   // request fields, bits 7:2
      logic [3:0][3:0] trim;      // termination trim codes
      logic [3:0][9:0] pend_off;  // pending offset values
      logic [3:0][9:0] cur_off;   // current offset values
      logic [3:0][9:0] cur_gain;  // current gain values
      logic [3:0][9:0] cur_phase; // current phase values
      logic [3:0][2:0] pend;      // queued ops: 0 gain 1 offset 2 phase
      logic [3:0]      busy;      // per-channel busy flags
      pcr_seq_t        seq;       // sequencer state
      logic [1:0]      seq_ch;    // channel being served
      logic [7:0]      cnt;       // cycles spent in current op
   } pcr_state_t;

   // state of the serial port engine
   typedef struct packed {
      logic [1:0]  sclk_s;  // serial clock synchroniser
      logic [1:0]  csn_s;   // select synchroniser
      logic [1:0]  mosi_s;  // data-in synchroniser
      logic        sclk_d;  // delayed synchronised clock
      logic [4:0]  cnt;     // bits received in this frame
      logic [23:0] sh_in;   // received bits
      logic [15:0] sh_out;  // read data being shifted out
      logic        miso;    // data-out bit
      logic        wr_stb;  // write frame complete
   } pcr_spi_t;

endpackage : pcr_pkg

// ==== design/pcr_spi_port.sv ====
// serial configuration port engine: samples the host pins on the system
// clock, collects frames and hands register reads and writes over
// assumes the serial clock is at most one eighth of the system clock
`timescale 1ns/1ns
`include "pcr_regs.svh"

module pcr_spi_port (
   // clock and reset
   input  wire logic        i_sys_clk,
   input  wire logic        i_rstn,
   // serial pins
   input  wire logic        i_spi_sclk,
   input  wire logic        i_spi_csn,
   input  wire logic        i_spi_mosi,
   output logic             o_spi_miso,
   // register side
   input  wire logic [15:0] i_rd_data,
   output logic [6:0]       o_rd_addr,
   output logic             o_wr_stb,
   output logic [6:0]       o_wr_addr,
   output logic [15:0]      o_wr_data
);

   pcr_pkg::pcr_spi_t r_reg;   // registered state
   pcr_pkg::pcr_spi_t r_next;  // next state
   logic              rise;    // serial clock rising edge
   logic              fall;    // serial clock falling edge

   // edges seen on the second synchroniser stage only
   assign rise = r_reg.sclk_s[1] & ~r_reg.sclk_d;
   assign fall = ~r_reg.sclk_s[1] & r_reg.sclk_d;

   // frame collection and read data shifting
   always_comb begin
      r_next        = r_reg;
      r_next.wr_stb = 1'b0;
      r_next.sclk_s = {r_reg.sclk_s[0], i_spi_sclk};
      r_next.csn_s  = {r_reg.csn_s[0], i_spi_csn};
      r_next.mosi_s = {r_reg.mosi_s[0], i_spi_mosi};
      r_next.sclk_d = r_reg.sclk_s[1];
      if (r_reg.csn_s[1]) begin
         // deselected: drop any partial frame
         r_next.cnt  = 5'h00;
         r_next.miso = 1'b0;
      end else if (rise && r_reg.cnt < `PCR_FRAME_BITS) begin
         // shift in one bit, write fires on the last one
         r_next.sh_in  = {r_reg.sh_in[22:0], r_reg.mosi_s[1]};
         r_next.cnt    = r_reg.cnt + 5'h01;
         r_next.wr_stb = (r_reg.cnt == `PCR_FRAME_BITS - 5'h01) &
                         ~r_reg.sh_in[22];
      end else if (fall && r_reg.cnt == `PCR_HDR_BITS) begin
         // header complete: present read data msb first
         r_next.miso   = i_rd_data[15];
         r_next.sh_out = {i_rd_data[14:0], 1'b0};
      end else if (fall && r_reg.cnt > `PCR_HDR_BITS) begin
         r_next.miso   = r_reg.sh_out[15];
         r_next.sh_out = {r_reg.sh_out[14:0], 1'b0};
      end
   end

   // state register
   always_ff @(posedge i_sys_clk) begin
      if (!i_rstn) begin
         r_reg       <= '0;
         r_reg.csn_s <= 2'h3;
      end else begin
         r_reg <= r_next;
      end
   end

   assign o_spi_miso = r_reg.miso;
   assign o_rd_addr  = r_reg.sh_in[6:0];
   assign o_wr_stb   = r_reg.wr_stb;
   assign o_wr_addr  = r_reg.sh_in[22:16];
   assign o_wr_data  = r_reg.sh_in[15:0];

endmodule : pcr_spi_port

// ==== design/pcr_bank.sv ====
// per-channel calibration register bank: request, mailbox, state, trim
// and pending offset registers for four channels, plus the sequencer
// that moves pending corrections into the current ones
// assumes the channel selector code and standby state come from logic
// on the same clock, and the host reaches it over the serial port
//
// Functional notes
// - per-channel copies, access reaches selected one
// - selector 001..100 picks channel, else none
// - request register 0x10, fields bits 7:2
// - offset code 10 copies pending offset
// - gain code 10 copies pending gain
// - phase code 10 copies pending phase
// - request write launches, busy until done
// - request fields keep written value afterwards
// - transfers run gain, offset, phase serially
// - mailbox 0x11 read-only, busy in bit 0
// - state 0x12 bit 0 active flag
// - trim 0x13, 4-bit code, reset 0111
// - pending offset 0x20, 10 bits, reset 0x200
// - offset code passes through unchanged
// - pending write leaves active offset alone
`timescale 1ns/1ns
`include "pcr_regs.svh"

module pcr_bank #(
   parameter int unsigned XFER_CYCLES = `PCR_XFER_CYCLES
) (
   // clock and reset
   input  wire logic            i_sys_clk,
   input  wire logic            i_rstn,
   // serial configuration pins
   input  wire logic            i_spi_sclk,
   input  wire logic            i_spi_csn,
   input  wire logic            i_spi_mosi,
   output logic                 o_spi_miso,
   // channel context
   input  wire logic [2:0]      i_chan_sel,
   input  wire logic [3:0]      i_chan_active,
   input  wire logic [3:0][9:0] i_pend_gain,
   input  wire logic [3:0][9:0] i_pend_phase,
   // correction values in use and busy flags
   output logic [3:0][9:0]      o_cur_offset,
   output logic [3:0][9:0]      o_cur_gain,
   output logic [3:0][9:0]      o_cur_phase,
   output logic [3:0][3:0]      o_trim_code,
   output logic [3:0]           o_chan_busy
);

   // bit positions of queued operations
   localparam int unsigned OP_GAIN   = 0;
   localparam int unsigned OP_OFFSET = 1;
   localparam int unsigned OP_PHASE  = 2;

   pcr_pkg::pcr_state_t r_reg;   // registered state
   pcr_pkg::pcr_state_t r_next;  // next state

   logic [15:0] rd_data;  // word presented to the serial port
   logic [6:0]  rd_addr;  // address of the read in progress
   logic        wr_stb;   // one-cycle write strobe
   logic [6:0]  wr_addr;  // write address
   logic [15:0] wr_data;  // write data
   logic [2:0]  sel;      // decoded selector: valid bit and index
   logic        sel_ok;   // a channel is selected
   logic [1:0]  sel_ch;   // selected channel index

   // selector decode, only four codes reach a channel
   function automatic logic [2:0] decode_sel(input logic [2:0] code);
      logic [2:0] d;
      d = 3'h0;
      case (code)
         `PCR_SEL_CH0: d = 3'h4;
         `PCR_SEL_CH1: d = 3'h5;
         `PCR_SEL_CH2: d = 3'h6;
         `PCR_SEL_CH3: d = 3'h7;
         default:      d = 3'h0;
      endcase
      return d;
   endfunction : decode_sel

   // first queued operation in priority order, idle if none
   function automatic pcr_pkg::pcr_seq_t first_op(input logic [2:0] q);
      pcr_pkg::pcr_seq_t s;
      s = pcr_pkg::PCR_SEQ_IDLE;
      if (q[OP_GAIN]) begin
         s = pcr_pkg::PCR_SEQ_GAIN;
      end else if (q[OP_OFFSET]) begin
         s = pcr_pkg::PCR_SEQ_OFFSET;
      end else if (q[OP_PHASE]) begin
         s = pcr_pkg::PCR_SEQ_PHASE;
      end
      return s;
   endfunction : first_op

   // a request field asks for a transfer only with the go code
   function automatic logic is_go(input logic [1:0] f);
      return f == `PCR_XFER_GO;
   endfunction : is_go

   // register read mux for the selected channel
   function automatic logic [15:0] read_word(
      input logic [6:0]          a,
      input pcr_pkg::pcr_state_t s,
      input logic                ok,
      input logic [1:0]          ch,
      input logic [3:0]          act
   );
      logic [15:0] w;
      w = 16'h0000;
      if (ok) begin
         case (a)
            // request fields read back as written, bits 1:0 zero
            `PCR_ADDR_CAL_REQ:  w = {8'h00, s.cal_req[ch], 2'h0};
            // mailbox: busy flag only
            `PCR_ADDR_MAILBOX:  w = {15'h0000, s.busy[ch]};
            // channel state: 1 active, 0 standby
            `PCR_ADDR_STATE:    w = {15'h0000, act[ch]};
            `PCR_ADDR_TRIM:     w = {12'h000, s.trim[ch]};
            `PCR_ADDR_PEND_OFF: w = {6'h00, s.pend_off[ch]};
            // unmapped addresses read zero
            default:            w = 16'h0000;
         endcase
      end
      return w;
   endfunction : read_word

   // serial port engine
   pcr_spi_port u_spi (
      .i_sys_clk  (i_sys_clk),
      .i_rstn     (i_rstn),
      .i_spi_sclk (i_spi_sclk),
      .i_spi_csn  (i_spi_csn),
      .i_spi_mosi (i_spi_mosi),
      .o_spi_miso (o_spi_miso),
      .i_rd_data  (rd_data),
      .o_rd_addr  (rd_addr),
      .o_wr_stb   (wr_stb),
      .o_wr_addr  (wr_addr),
      .o_wr_data  (wr_data)
   );

   // channel routing from the selector code
   assign sel    = decode_sel(i_chan_sel);
   assign sel_ok = sel[2];
   assign sel_ch = sel[1:0];

   // read data routed from the selected copy only
   assign rd_data = read_word(rd_addr, r_reg, sel_ok, sel_ch,
                              i_chan_active);

   // next-state logic: sequencer first, then host writes, then the
   // choice of the next operation from the merged queue
   always_comb begin
      logic [2:0] newq;  // operations requested by this write
      logic       done;  // current operation finishes now
      logic [1:0] pick;  // lowest channel with queued work
      logic       any;   // some channel has queued work
      newq   = 3'h0;
      done   = 1'b0;
      pick   = 2'h0;
      any    = 1'b0;
      r_next = r_reg;

      // run the operation in progress
      if (r_reg.seq != pcr_pkg::PCR_SEQ_IDLE) begin
         done = r_reg.cnt == 8'(XFER_CYCLES - 1);
         if (!done) begin
            r_next.cnt = r_reg.cnt + 8'h01;
         end
      end

      // on completion copy the pending value and retire the op
      if (done) begin
         r_next.cnt = 8'h00;
         unique case (r_reg.seq)
            pcr_pkg::PCR_SEQ_GAIN: begin
               // gain copied from its pending source
               r_next.cur_gain[r_reg.seq_ch] =
                  i_pend_gain[r_reg.seq_ch];
               r_next.pend[r_reg.seq_ch][OP_GAIN] = 1'b0;
            end
            pcr_pkg::PCR_SEQ_OFFSET: begin
               // offset code copied unchanged, active only now
               r_next.cur_off[r_reg.seq_ch] =
                  r_reg.pend_off[r_reg.seq_ch];
               r_next.pend[r_reg.seq_ch][OP_OFFSET] = 1'b0;
            end
            pcr_pkg::PCR_SEQ_PHASE: begin
               // phase copied from its pending source
               r_next.cur_phase[r_reg.seq_ch] =
                  i_pend_phase[r_reg.seq_ch];
               r_next.pend[r_reg.seq_ch][OP_PHASE] = 1'b0;
            end
            pcr_pkg::PCR_SEQ_IDLE: begin
               r_next.cnt = 8'h00;
            end
         endcase
      end

      // host writes reach the selected channel only
      if (wr_stb && sel_ok) begin
         case (wr_addr)
            `PCR_ADDR_CAL_REQ: begin
               // fields stored as written, never cleared by hardware
               r_next.cal_req[sel_ch] =
                  wr_data[7:2];
               newq[OP_GAIN]   =
                  is_go(wr_data[`PCR_REQ_GAIN_LSB +: 2]);
               newq[OP_OFFSET] =
                  is_go(wr_data[`PCR_REQ_OFFSET_LSB +: 2]);
               newq[OP_PHASE]  =
                  is_go(wr_data[`PCR_REQ_PHASE_LSB +: 2]);
               // a new request joins any queued work; set beats clear
               r_next.pend[sel_ch] =
                  r_next.pend[sel_ch] | newq;
            end
            `PCR_ADDR_TRIM: begin
               r_next.trim[sel_ch] = wr_data[3:0];
            end
            `PCR_ADDR_PEND_OFF: begin
               // stored only, current offset untouched here
               r_next.pend_off[sel_ch] = wr_data[9:0];
            end
            // read-only and unmapped addresses ignore writes
            default: begin
               r_next.pend_off = r_next.pend_off;
            end
         endcase
      end

      // choose what runs next
      if (r_reg.seq == pcr_pkg::PCR_SEQ_IDLE || done) begin
         if (done && |r_next.pend[r_reg.seq_ch]) begin
            // finish the same channel before serving another
            r_next.seq = first_op(r_next.pend[r_reg.seq_ch]);
         end else begin
            // lowest-numbered channel with queued work
            for (int c = 3; c >= 0; c--) begin
               if (|r_next.pend[c]) begin
                  pick = 2'(c);
                  any  = 1'b1;
               end
            end
            r_next.seq_ch = pick;
            r_next.seq    = any ? first_op(r_next.pend[pick])
                                : pcr_pkg::PCR_SEQ_IDLE;
         end
      end

      // busy stands while any launched op of the channel is open
      for (int c = 0; c < 4; c++) begin
         r_next.busy[c] = |r_next.pend[c];
      end
   end

   // state register, reset values per field
   always_ff @(posedge i_sys_clk) begin
      if (!i_rstn) begin
         r_reg           <= '0;
         r_reg.trim      <= {4{`PCR_TRIM_RST}};
         r_reg.pend_off  <= {4{`PCR_CORR_RST}};
         r_reg.cur_off   <= {4{`PCR_CORR_RST}};
         r_reg.cur_gain  <= {4{`PCR_CORR_RST}};
         r_reg.cur_phase <= {4{`PCR_CORR_RST}};
      end else begin
         r_reg <= r_next;
      end
   end

   // outputs straight from the state register
   assign o_cur_offset = r_reg.cur_off;
   assign o_cur_gain   = r_reg.cur_gain;
   assign o_cur_phase  = r_reg.cur_phase;
   assign o_trim_code  = r_reg.trim;
   assign o_chan_busy  = r_reg.busy;

endmodule : pcr_bank

// ==== testbench/pcr_bank_properties.sv ====
// assertions on the ports of the calibration register bank
// assumes a bind onto pcr_bank that hands on the transfer length
`timescale 1ns/1ns

module pcr_bank_props #(
   parameter int unsigned XFER_CYCLES = 4  // cycles of one transfer
) (
   // clock and reset
   input wire logic            i_sys_clk,
   input wire logic            i_rstn,
   // channel context and results
   input wire logic [2:0]      i_chan_sel,
   input wire logic [3:0][9:0] o_cur_offset,
   input wire logic [3:0][9:0] o_cur_gain,
   input wire logic [3:0][9:0] o_cur_phase,
   input wire logic [3:0][3:0] o_trim_code,
   input wire logic [3:0]      o_chan_busy
);
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_rstn);

   logic [3:0][9:0] off_q, gain_q, ph_q; // values a cycle ago
   logic [3:0][3:0] trim_q;              // trim codes a cycle ago
   logic [3:0]      busy_q, sel_q;       // busy and selection a cycle ago
   logic [3:0]      sel_oh, chg_ch;      // selected channel, changed ones
   logic [2:0]      chg_k;               // kinds of value that changed
   logic [15:0]     sel_nib;             // trim nibbles of sel_q
   logic            up_q;                // last cycle was out of reset
   logic [9:0]      gap_q, run_q;        // since change, busy run length

   // decode the selector and find what changed
   always_comb begin
      sel_oh = 4'h0;
      if (i_chan_sel >= 3'h1 && i_chan_sel <= 3'h4)
         sel_oh = 4'h1 << (i_chan_sel - 3'h1);
      chg_k = {o_cur_offset != off_q, o_cur_gain != gain_q,
               o_cur_phase != ph_q};
      for (int c = 0; c < 4; c++) begin
         chg_ch[c] = (o_cur_offset[c] != off_q[c]) ||
                     (o_cur_gain[c] != gain_q[c]) ||
                     (o_cur_phase[c] != ph_q[c]);
         sel_nib[4*c +: 4] = {4{sel_q[c]}};
      end
   end

   // history; around reset the gap counter is preset to its maximum and the run counter cleared
   always_ff @(posedge i_sys_clk) begin
      up_q   <= i_rstn;
      off_q  <= o_cur_offset;
      gain_q <= o_cur_gain;
      ph_q   <= o_cur_phase;
      trim_q <= o_trim_code;
      busy_q <= o_chan_busy;
      sel_q  <= sel_oh;
      if (!i_rstn || !up_q)
         gap_q <= 10'h3ff;
      else if (|chg_ch)
         gap_q <= 10'h0;
      else if (gap_q != 10'h3ff)
         gap_q <= gap_q + 10'h1;
      if (!i_rstn || o_chan_busy == 4'h0)
         run_q <= 10'h0;
      else if (run_q != 10'h3ff)
         run_q <= run_q + 10'h1;
   end

   AST_RST_VALUES: assert property (
      $rose(i_rstn) |-> o_trim_code == {4{4'h7}} &&
      o_chan_busy == 4'h0 && o_cur_offset == {4{10'h200}})
      else $error("outputs not at reset values");
   AST_CHG_NEEDS_BUSY: assert property (
      up_q |-> (chg_ch & ~busy_q) == 4'h0)
      else $error("correction changed without a transfer");
   AST_ONE_AT_A_TIME: assert property (
      up_q |-> $onehot0(chg_ch) && $onehot0(chg_k))
      else $error("two corrections changed together");
   AST_XFER_SPACING: assert property (
      up_q && |chg_ch |-> gap_q >= 10'(XFER_CYCLES - 1))
      else $error("transfers closer than one transfer time");
   AST_BUSY_LENGTH: assert property (
      up_q && busy_q != 4'h0 && o_chan_busy == 4'h0 |->
      run_q >= 10'(XFER_CYCLES - 1))
      else $error("busy shorter than one transfer");
   AST_BUSY_SEL: assert property (
      up_q |-> (o_chan_busy & ~busy_q & ~sel_q) == 4'h0)
      else $error("busy rose on an unselected channel");
   AST_TRIM_SEL: assert property (
      up_q |-> ((o_trim_code ^ trim_q) & ~sel_nib) == 16'h0)
      else $error("trim changed on an unselected channel");
   AST_TRIM_NOSEL: assert property (
      up_q && sel_q == 4'h0 |-> $stable(o_trim_code))
      else $error("trim changed with no channel selected");

   // main scenarios reached
   COV_XFER: cover property (up_q && |chg_ch);
   COV_BUSY: cover property ($rose(o_chan_busy[1]));
   COV_TRIM: cover property (up_q && o_trim_code != trim_q);
endmodule : pcr_bank_props

// ==== testbench/pcr_spi_host.sv ====
// serial host model that sends configuration frames to the bank
// assumes the bank samples the pins on the same system clock
`timescale 1ns/1ns

module pcr_spi_host #(
   parameter int HALF = 6  // system clocks per serial clock phase
) (
   // system clock and read data
   input  wire logic i_sys_clk,
   input  wire logic i_miso,
   // serial pins toward the bank
   output logic      o_sclk,
   output logic      o_csn,
   output logic      o_mosi
);
   // idle: serial clock still and low, bank deselected
   initial begin
      o_sclk = 1'b0;
      o_csn  = 1'b1;
      o_mosi = 1'b0;
   end

   // one frame: direction, address, data, msb first
   task automatic xfer(input logic rd, input logic [6:0] a,
                       input logic [15:0] d, output logic [15:0] q);
      logic [23:0] fr;
      fr = {rd, a, d};
      q = 16'h0;
      @(posedge i_sys_clk);
      #1;
      o_csn = 1'b0;
      for (int i = 23; i >= 0; i--) begin
         o_mosi = fr[i];
         repeat (HALF) @(posedge i_sys_clk);
         #1;
         o_sclk = 1'b1;
         if (i < 16)
            q = {q[14:0], i_miso};  // read bit sampled on the rise
         repeat (HALF) @(posedge i_sys_clk);
         #1;
         o_sclk = 1'b0;
      end
      repeat (HALF) @(posedge i_sys_clk);
      #1;
      o_csn = 1'b1;
      o_mosi = ~o_mosi;  // released line must not keep its level
      repeat (HALF) @(posedge i_sys_clk);  // gap between frames
      #1;
   endtask : xfer
endmodule : pcr_spi_host

// ==== testbench/tb_per_channel_calibration_regs.sv ====
// self-checking bench for the calibration register bank
// assumes the serial host model drives the pins; checker bound below
`timescale 1ns/1ns
`include "pcr_regs.svh"

module tb_per_channel_calibration_regs;
   localparam int XC = 100;  // long transfers so busy shows on reads
   logic            i_sys_clk, i_rstn, sclk, csn, mosi, miso;
   logic [2:0]      i_chan_sel;
   logic [3:0]      i_chan_active;
   logic [3:0][9:0] i_pend_gain, i_pend_phase;
   logic [3:0][9:0] o_cur_offset, o_cur_gain, o_cur_phase;
   logic [3:0][3:0] o_trim_code;
   logic [3:0]      o_chan_busy;
   int              num_errors, n_compared, cyc, t_br, t_bf, t_g, t_o, t_p;
   logic [15:0]     rdata;
   logic            b_q;
   logic [9:0]      g_q, o_q, p_q, eg, eo, ep;

   pcr_bank #(.XFER_CYCLES(XC)) dut_u (
      .i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_spi_sclk(sclk),
      .i_spi_csn(csn), .i_spi_mosi(mosi), .o_spi_miso(miso),
      .i_chan_sel(i_chan_sel), .i_chan_active(i_chan_active),
      .i_pend_gain(i_pend_gain), .i_pend_phase(i_pend_phase),
      .o_cur_offset(o_cur_offset), .o_cur_gain(o_cur_gain),
      .o_cur_phase(o_cur_phase), .o_trim_code(o_trim_code),
      .o_chan_busy(o_chan_busy));
   pcr_spi_host host_u (.i_sys_clk(i_sys_clk), .i_miso(miso),
      .o_sclk(sclk), .o_csn(csn), .o_mosi(mosi));

   // 100 MHz system clock
   initial begin
      i_sys_clk = 1'b0;
      forever #5 i_sys_clk = ~i_sys_clk;
   end

   // marks the cycle of each busy edge and value change of channel 1
   always @(negedge i_sys_clk) begin
      cyc++;
      if (o_chan_busy[1] !== b_q && o_chan_busy[1] === 1'b1)
         t_br = cyc;
      if (o_chan_busy[1] !== b_q && o_chan_busy[1] === 1'b0)
         t_bf = cyc;
      if (o_cur_gain[1] !== g_q)
         t_g = cyc;
      if (o_cur_offset[1] !== o_q)
         t_o = cyc;
      if (o_cur_phase[1] !== p_q)
         t_p = cyc;
      b_q = o_chan_busy[1];
      g_q = o_cur_gain[1];
      o_q = o_cur_offset[1];
      p_q = o_cur_phase[1];
   end

   task automatic tick(input int n);
      repeat (n) @(posedge i_sys_clk);
      #1;
   endtask : tick

   task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk16

   task automatic chk10(input logic [9:0] got, input logic [9:0] exp);
      chk16({6'h0, got}, {6'h0, exp});
   endtask : chk10

   task automatic wr(input logic [6:0] a, input logic [15:0] d);
      logic [15:0] q;
      host_u.xfer(1'b0, a, d, q);
   endtask : wr

   task automatic rdchk(input logic [6:0] a, input logic [15:0] exp);
      host_u.xfer(1'b1, a, 16'h0, rdata);
      chk16(rdata, exp);
   endtask : rdchk

   // poll the mailbox a bounded number of times until idle
   task automatic wait_idle;
      int k;
      k = 0;
      rdata = 16'h0001;
      while (rdata[0] !== 1'b0 && k < 10) begin
         host_u.xfer(1'b1, `PCR_ADDR_MAILBOX, 16'h0, rdata);
         k++;
      end
      if (rdata[0] !== 1'b0) begin
         chk16(rdata, 16'h0000);
         end_of_test;
      end
   endtask : wait_idle

   task automatic end_of_test;
      $display("compared %0d mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : end_of_test

   initial begin
      num_errors = 0;
      n_compared = 0;
      cyc = 0;
      i_rstn = 1'b0;
      i_chan_sel = 3'h0;
      i_chan_active = 4'h5;
      i_pend_gain = {4{10'h200}};
      i_pend_phase = {4{10'h200}};
      tick(2);
      i_rstn = 1'b1;
      tick(4);
      // reset values, then distinct trim and pending offset per channel
      for (int c = 0; c < 4; c++) begin
         i_chan_sel = 3'(c + 1);
         chk16(16'(o_trim_code[c]), 16'h0007);
         rdchk(`PCR_ADDR_TRIM, 16'h0007);
         rdchk(`PCR_ADDR_PEND_OFF, 16'h0200);
         rdchk(`PCR_ADDR_CAL_REQ, 16'h0000);
         rdchk(`PCR_ADDR_STATE, 16'(c % 2 == 0));
         wr(`PCR_ADDR_TRIM, 16'(16'hfff8 + c));
         wr(`PCR_ADDR_PEND_OFF, 16'(16'hfd00 + c));
      end
      for (int c = 0; c < 4; c++) begin
         i_chan_sel = 3'(c + 1);
         rdchk(`PCR_ADDR_TRIM, 16'(8 + c));
         rdchk(`PCR_ADDR_PEND_OFF, 16'(16'h0100 + c));
         chk10(o_cur_offset[c], 10'h200);
      end
      $display("test per-channel copies done");
      // codes 000, 101 and 111 reach no channel
      for (int k = 0; k < 3; k++) begin
         i_chan_sel = (k == 0) ? 3'h0 : (k == 1) ? 3'h5 : 3'h7;
         wr(`PCR_ADDR_TRIM, 16'h0001);
         rdchk(`PCR_ADDR_TRIM, 16'h0000);
      end
      chk16(o_trim_code, {4'hb, 4'ha, 4'h9, 4'h8});
      // read-only places, standby flag, unmapped address
      i_chan_sel = 3'h2;
      wr(`PCR_ADDR_MAILBOX, 16'hffff);
      rdchk(`PCR_ADDR_MAILBOX, 16'h0000);
      rdchk(`PCR_ADDR_STATE, 16'h0000);
      i_chan_active = 4'hf;
      rdchk(`PCR_ADDR_STATE, 16'h0001);
      rdchk(7'h30, 16'h0000);
      $display("test read-only done");
      // idle codes 00, 01 and 11 in every field launch nothing
      for (int k = 0; k < 3; k++) begin
         rdata = (k == 0) ? 16'h0000 : (k == 1) ? 16'h0054 : 16'hffff;
         wr(`PCR_ADDR_CAL_REQ, rdata);
         chk16(16'(o_chan_busy), 16'h0000);
         rdchk(`PCR_ADDR_CAL_REQ, rdata & 16'h00fc);
         chk10(o_cur_offset[1], 10'h200);
      end
      $display("test idle codes done");
      // all three transfers together on channel 1
      i_pend_gain[1] = 10'h155;
      i_pend_phase[1] = 10'h2aa;
      wr(`PCR_ADDR_PEND_OFF, 16'h03ff);
      wr(`PCR_ADDR_CAL_REQ, 16'h00a8);
      rdchk(`PCR_ADDR_MAILBOX, 16'h0001);
      wait_idle;
      chk16(16'(t_g - t_br), 16'(XC));
      chk16(16'(t_o - t_g), 16'(XC));
      chk16(16'(t_p - t_o), 16'(XC));
      chk16(16'(t_bf - t_p), 16'h0000);
      chk10(o_cur_gain[1], 10'h155);
      chk10(o_cur_offset[1], 10'h3ff);
      chk10(o_cur_phase[1], 10'h2aa);
      chk10(o_cur_offset[0], 10'h200);
      rdchk(`PCR_ADDR_CAL_REQ, 16'h00a8);
      $display("test chained transfer done");
      // one transfer at a time on channel 2
      i_chan_sel = 3'h3;
      eg = 10'h200;
      eo = 10'h200;
      ep = 10'h200;
      for (int k = 0; k < 3; k++) begin
         i_pend_gain[2] = 10'(10'h100 + k);
         i_pend_phase[2] = 10'(10'h080 + k);
         wr(`PCR_ADDR_PEND_OFF, 16'(10'(k - 1)));
         wr(`PCR_ADDR_CAL_REQ, (k == 0) ? 16'h0020 :
                               (k == 1) ? 16'h0008 : 16'h0080);
         wait_idle;
         if (k == 0)
            eg = 10'h100;
         if (k == 1)
            eo = 10'h000;
         if (k == 2)
            ep = 10'h082;
         chk10(o_cur_gain[2], eg);
         chk10(o_cur_offset[2], eo);
         chk10(o_cur_phase[2], ep);
      end
      $display("test single transfers done");
      end_of_test;
   end
endmodule : tb_per_channel_calibration_regs

bind pcr_bank pcr_bank_props #(.XFER_CYCLES(XFER_CYCLES)) props_u (
   .i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_chan_sel(i_chan_sel),
   .o_cur_offset(o_cur_offset), .o_cur_gain(o_cur_gain),
   .o_cur_phase(o_cur_phase), .o_trim_code(o_trim_code),
   .o_chan_busy(o_chan_busy));
